// >>> core/host_frame_index_status.sv
/*
 * Microframe index counter with frame-wrap and port-change status
 * flags, reached as a classic Wishbone slave.
 * Assumes port event inputs come from port logic on core_clk, so they
 * are used without synchronisers; srst is synchronous to core_clk.
 */
// How it works
// - The frame-wrap flag (status bit 3) sets when the list index wraps.
// - The port-change flag (bit 2) sets on a new change bit of an owned port.
// - It also sets when a suspended port's forced-resume bit rises.
// - Offset 0x28 is a read/write location whose bits do nothing.
// - The index increments once per 125 us microframe.
// - The list entry is index bits 3 upward, sized by the list size field.
// - Index bits 13:0 give the SOF number and list index; writes retime both.
// - Reset clears the index and both flags; index bits 31:14 read zero.
// - A flag clears only on a written one; set beats clear.
`timescale 1ns/1ps

module host_frame_index_status #(
    parameter int NPORTS = 3,
    parameter int MF_CYCLES = frame_index_pkg::MICROFRAME_CYCLES
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire frame_index_pkg::wbReq_s wbReq,
    output logic [frame_index_pkg::DATA_W-1:0] wbDatOut,
    output logic wbAck,
    input wire logic [NPORTS-1:0] portChange,
    input wire logic [NPORTS-1:0] portHandoff,
    input wire logic [NPORTS-1:0] forcedResume,
    input wire logic [NPORTS-1:0] portSuspended,
    output logic [frame_index_pkg::INDEX_W-1:0] sofFrameNumber,
    output logic [frame_index_pkg::ENTRY_W-1:0] frameListEntry,
    output logic microframeTick
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    localparam int CNT_W = $clog2(MF_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(MF_CYCLES - 1);

    // wrap mask on the index: 1024, 512 or 256 entries of 8 microframes
    function automatic logic [frame_index_pkg::INDEX_W-1:0] wrapMask(
        input logic [1:0] size
    );
        case (size)
            2'h1: wrapMask = 14'h0fff;
            2'h2: wrapMask = 14'h07ff;
            default: wrapMask = 14'h1fff;
        endcase
    endfunction

    function automatic logic [frame_index_pkg::ENTRY_W-1:0] entryOf(
        input logic [frame_index_pkg::INDEX_W-1:0] idx,
        input logic [1:0] size
    );
        logic [frame_index_pkg::INDEX_W-1:0] m;
        m = idx & wrapMask(size);
        entryOf = m[frame_index_pkg::ENTRY_LSB +: frame_index_pkg::ENTRY_W];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // state

    logic ack_r, runStop_r, tick_r, flagWrap_r, flagPort_r;
    logic [frame_index_pkg::DATA_W-1:0] rdat_r, irqEnable_r;
    logic [1:0] listSize_r;
    logic [frame_index_pkg::INDEX_W-1:0] index_r, index_nxt;
    logic [CNT_W-1:0] mfCount_r;
    logic [NPORTS-1:0] portOwned_r, resumeSeen_r;
    logic [frame_index_pkg::ENTRY_W-1:0] entry_r;

    ////////////////////////////////////////////////////////////////////
    // bus decode

    wire access = wbReq.cyc && wbReq.stb && !ack_r;
    wire wrAcc = access && wbReq.we;
    wire selCmd = wbReq.adr == frame_index_pkg::HOST_COMMAND_OFS;
    wire selSts = wbReq.adr == frame_index_pkg::HOST_STATUS_OFS;
    wire selIrq = wbReq.adr == frame_index_pkg::HOST_IRQ_ENABLE_OFS;
    wire selIdx = wbReq.adr == frame_index_pkg::MICROFRAME_INDEX_OFS;
    wire [frame_index_pkg::DATA_W-1:0] byteMask = {
        {8{wbReq.sel[3]}}, {8{wbReq.sel[2]}},
        {8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};
    wire [frame_index_pkg::DATA_W-1:0] wrMasked = wbReq.dat & byteMask;
    wire wrCmd = wrAcc && selCmd && wbReq.sel[0];
    wire wrIdx = wrAcc && selIdx;
    wire clrWrap = wrAcc && selSts
        && wrMasked[frame_index_pkg::FRAME_WRAP_BIT];
    wire clrPort = wrAcc && selSts
        && wrMasked[frame_index_pkg::PORT_CHANGE_BIT];

    wire [frame_index_pkg::DATA_W-1:0] cmdView =
        {28'h0000000, listSize_r, 1'b0, runStop_r};
    wire [frame_index_pkg::DATA_W-1:0] stsView =
        {28'h0000000, flagWrap_r, flagPort_r, 2'h0};
    // reserved bits 31:14 of the index read zero
    wire [frame_index_pkg::DATA_W-1:0] idxView =
        {18'h00000, index_r};
    // unmapped offsets read zero and still acknowledge
    wire [frame_index_pkg::DATA_W-1:0] rdMux =
        selCmd ? cmdView : selSts ? stsView :
        selIrq ? irqEnable_r : selIdx ? idxView : 32'h0000_0000;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= access;
            rdat_r <= access ? rdMux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // command and reserved enable register

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            runStop_r <= 1'b0;
            listSize_r <= frame_index_pkg::LIST_SIZE_RST;
            irqEnable_r <= frame_index_pkg::IRQ_ENABLE_RST;
        end
        else
        begin
            if (wrCmd)
            begin
                runStop_r <= wbReq.dat[frame_index_pkg::RUN_STOP_BIT];
                listSize_r <=
                    wbReq.dat[frame_index_pkg::LIST_SIZE_LSB +: 2];
            end
            // stored and read back, steers nothing
            if (wrAcc && selIrq)
                irqEnable_r <= (irqEnable_r & ~byteMask) | wrMasked;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // microframe timer and index

    wire tickNow = runStop_r && mfCount_r == CNT_LAST;
    // only the bits that the list size uses take part in the wrap
    wire [frame_index_pkg::INDEX_W-1:0] curMask = wrapMask(listSize_r);
    wire wrapNow = tickNow && (index_r & curMask) == curMask;
    wire [frame_index_pkg::INDEX_W-1:0] idxWrite =
        (index_r & ~byteMask[frame_index_pkg::INDEX_W-1:0])
        | wrMasked[frame_index_pkg::INDEX_W-1:0];

    // a write retimes numbering; a write while running is not fenced off
    assign index_nxt = wrIdx ? idxWrite
        : tickNow ? index_r + 14'h0001 : index_r;

    always_ff @(posedge core_clk)
    begin
        if (srst || !runStop_r || tickNow)
            mfCount_r <= '0;
        else
            mfCount_r <= mfCount_r + 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            index_r <= frame_index_pkg::INDEX_RST;
            tick_r <= 1'b0;
            entry_r <= '0;
        end
        else
        begin
            index_r <= index_nxt;
            tick_r <= tickNow;
            entry_r <= entryOf(index_nxt, listSize_r);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // port events and status flags

    wire [NPORTS-1:0] owned = portChange & ~portHandoff;
    wire [NPORTS-1:0] resumed = forcedResume & portSuspended;
    wire portEvt = |(owned & ~portOwned_r);
    wire resumeEvt = |(resumed & ~resumeSeen_r);

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            portOwned_r <= '0;
            resumeSeen_r <= '0;
            flagWrap_r <= 1'b0;
            flagPort_r <= 1'b0;
        end
        else
        begin
            portOwned_r <= owned;
            resumeSeen_r <= resumed;
            // set beats a same-cycle clear
            flagWrap_r <= wrapNow || (flagWrap_r && !clrWrap);
            flagPort_r <= portEvt || resumeEvt
                || (flagPort_r && !clrPort);
        end
    end

    assign wbAck = ack_r;
    assign wbDatOut = rdat_r;
    assign sofFrameNumber = index_r;
    assign frameListEntry = entry_r;
    assign microframeTick = tick_r;

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence s_stsWrite(int bitPos);
        wrAcc && selSts && wrMasked[bitPos];
    endsequence

    // a write in the wrap cycle wins over the step, so only the flag holds
    property p_wrapSets;
        wrapNow |=> flagWrap_r && ($past(wrIdx)
            || (index_r & wrapMask($past(listSize_r))) == 14'h0000);
    endproperty
    a_wrapSets: assert property (p_wrapSets)
        else $error("wrap tick did not set flag");

    property p_portSets;
        portEvt |=> flagPort_r;
    endproperty
    a_portSets: assert property (p_portSets)
        else $error("owned port change did not set flag");

    property p_resumeSets;
        resumeEvt |=> flagPort_r ##1 (flagPort_r || $past(clrPort));
    endproperty
    a_resumeSets: assert property (p_resumeSets)
        else $error("forced resume did not set flag");

    property p_irqStore;
        wrAcc && selIrq && wbReq.sel == 4'hf |=>
            irqEnable_r == $past(wbReq.dat);
    endproperty
    a_irqStore: assert property (p_irqStore)
        else $error("enable location lost written data");

    // the counter restarts, so the next step is a full microframe away
    property p_indexStep;
        tickNow && !wrIdx |=> index_r == $past(index_r) + 14'h0001
            && tick_r && mfCount_r == '0;
    endproperty
    a_indexStep: assert property (p_indexStep)
        else $error("index did not step once per microframe");

    property p_entry;
        !wrCmd |=> frameListEntry == entryOf(index_r, listSize_r);
    endproperty
    a_entry: assert property (p_entry)
        else $error("list entry does not follow index");

    property p_idxWrite;
        wrIdx && wbReq.sel == 4'hf |=>
            sofFrameNumber == $past(wbReq.dat[13:0]);
    endproperty
    a_idxWrite: assert property (p_idxWrite)
        else $error("index write did not retime SOF number");

    property p_afterReset;
        $past(srst) |-> index_r == 14'h0000 && !flagWrap_r && !flagPort_r;
    endproperty
    a_afterReset: assert property (p_afterReset)
        else $error("state not cleared by reset");

    property p_flagClear;
        s_stsWrite(frame_index_pkg::FRAME_WRAP_BIT) and !wrapNow
            |=> !flagWrap_r;
    endproperty
    a_flagClear: assert property (p_flagClear)
        else $error("written one did not clear wrap flag");

    property p_flagHold;
        flagPort_r && !clrPort |=> flagPort_r;
    endproperty
    a_flagHold: assert property (p_flagHold)
        else $error("port flag dropped without a written one");

    property p_noFalseWrap;
        !flagWrap_r && !wrapNow |=> !flagWrap_r;
    endproperty
    a_noFalseWrap: assert property (p_noFalseWrap)
        else $error("wrap flag set without a list wrap");
endmodule

// >>> core/frame_index_pkg.sv
/*
 * Shared constants and carrier types for the microframe index and
 * host status block: register offsets, field positions, reset values,
 * microframe timing and the Wishbone request struct.
 * Assumes a 100 MHz core clock and a 32-bit classic Wishbone master.
 */
package frame_index_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int INDEX_W = 14;
    localparam int ENTRY_W = 10;

    // register byte offsets
    localparam logic [ADDR_W-1:0] HOST_COMMAND_OFS = 8'h20;
    localparam logic [ADDR_W-1:0] HOST_STATUS_OFS = 8'h24;
    localparam logic [ADDR_W-1:0] HOST_IRQ_ENABLE_OFS = 8'h28;
    localparam logic [ADDR_W-1:0] MICROFRAME_INDEX_OFS = 8'h2c;

    // field positions
    localparam int RUN_STOP_BIT = 0;
    localparam int LIST_SIZE_LSB = 2;
    localparam int PORT_CHANGE_BIT = 2;
    localparam int FRAME_WRAP_BIT = 3;
    localparam int ENTRY_LSB = 3;

    // reset values
    localparam logic [INDEX_W-1:0] INDEX_RST = 14'h0000;
    localparam logic [DATA_W-1:0] IRQ_ENABLE_RST = 32'h0000_0000;
    localparam logic [1:0] LIST_SIZE_RST = 2'h0;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MICROFRAME_NS = 125000;
    localparam int MICROFRAME_CYCLES = MICROFRAME_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADDR_W-1:0] adr;
        logic [3:0] sel;
        logic [DATA_W-1:0] dat;
    } wbReq_s;

endpackage

// >>> dv/host_frame_index_status_tb.sv
/*
 * Self-checking bench for the microframe index and host status block.
 * Assumes the design package is compiled first; drives the Wishbone
 * slave and the port event inputs directly, with no partner model.
 */
`timescale 1ns/1ps

module host_frame_index_status_tb;

    localparam int MF = 8;

    logic coreClk = 1'b0;
    logic srst = 1'b1;
    frame_index_pkg::wbReq_s wbReq = '0;
    logic [31:0] wbDatOut;
    logic wbAck;
    logic [2:0] portChange = 3'h0;
    logic [2:0] portHandoff = 3'h0;
    logic [2:0] forcedResume = 3'h0;
    logic [2:0] portSuspended = 3'h0;
    logic [13:0] sofFrameNumber;
    logic [9:0] frameListEntry;
    logic microframeTick;
    int numErrors = 0;
    int checked = 0;
    logic [31:0] rd;
    logic [13:0] start;
    logic [1:0] sz;
    int gap;

    always #5 coreClk = ~coreClk;

    host_frame_index_status #(.NPORTS(3), .MF_CYCLES(MF))
        u_host_frame_index_status (
        .core_clk(coreClk),
        .srst(srst),
        .wbReq(wbReq),
        .wbDatOut(wbDatOut),
        .wbAck(wbAck),
        .portChange(portChange),
        .portHandoff(portHandoff),
        .forcedResume(forcedResume),
        .portSuspended(portSuspended),
        .sofFrameNumber(sofFrameNumber),
        .frameListEntry(frameListEntry),
        .microframeTick(microframeTick)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, numErrors);
        if (numErrors == 0 && checked > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // entered right after a rising edge; holds until ack is sampled
    task automatic wb_cycle(input logic w, input logic [7:0] a,
                            input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
        do
        begin
            @(posedge coreClk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            numErrors++;
            tally_and_finish();
        end
        q = wbDatOut;
        wbReq <= '0;
        @(posedge coreClk);
    endtask

    task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        wb_cycle(1'b1, a, d, unused);
    endtask

    task automatic port_event(input logic [2:0] chg, input logic [2:0] frc);
        portChange <= chg;
        forcedResume <= frc;
        repeat (2) @(posedge coreClk);
        portChange <= 3'h0;
        forcedResume <= 3'h0;
        @(posedge coreClk);
    endtask

    // returns cycles since the call; a missing tick ends the run
    task automatic wait_tick(output int n);
        n = 0;
        do
        begin
            @(posedge coreClk);
            n++;
        end while (microframeTick !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            numErrors++;
            tally_and_finish();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge coreClk);
        srst <= 1'b0;
        @(posedge coreClk);
        wb_cycle(1'b0, 8'h24, 32'h0, rd);
        check("status", rd, 32'h0);
        wb_cycle(1'b0, 8'h2c, 32'h0, rd);
        check("index", rd, 32'h0);
        wb_cycle(1'b0, 8'h28, 32'h0, rd);
        check("irq enable", rd, 32'h0);
        wb_wr(8'h28, 32'ha5c3_0f96);
        wb_cycle(1'b0, 8'h28, 32'h0, rd);
        check("irq enable", rd, 32'ha5c3_0f96);
        wb_wr(8'h40, 32'hffff_ffff);
        wb_cycle(1'b0, 8'h40, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        $display("test registers done");

        // port 1 is handed off, only port 2 is suspended
        portHandoff <= 3'h2;
        portSuspended <= 3'h4;
        port_event(3'h2, 3'h2);
        wb_cycle(1'b0, 8'h24, 32'h0, rd);
        check("status", rd, 32'h0);
        port_event(3'h1, 3'h0);
        wb_cycle(1'b0, 8'h24, 32'h0, rd);
        check("status", rd, 32'h4);
        wb_wr(8'h24, 32'h0);
        wb_cycle(1'b0, 8'h24, 32'h0, rd);
        check("status", rd, 32'h4);
        wb_wr(8'h24, 32'h4);
        wb_cycle(1'b0, 8'h24, 32'h0, rd);
        check("status", rd, 32'h0);
        port_event(3'h0, 3'h4);
        wb_cycle(1'b0, 8'h24, 32'h0, rd);
        check("status", rd, 32'h4);
        wb_wr(8'h24, 32'h4);
        $display("test port events done");

        // full word, reserved upper bits written as zero
        wb_wr(8'h2c, 32'h0000_3ff8);
        wb_cycle(1'b0, 8'h2c, 32'h0, rd);
        check("index", rd, 32'h3ff8);
        check("sof", {18'h0, sofFrameNumber}, 32'h3ff8);
        check("entry", {22'h0, frameListEntry}, 32'h3ff);
        wb_wr(8'h20, 32'h8);
        check("entry", {22'h0, frameListEntry}, 32'hff);
        // size code 3 falls back to the full 1024 list
        wb_wr(8'h20, 32'hc);
        check("entry", {22'h0, frameListEntry}, 32'h3ff);
        wb_cycle(1'b0, 8'h20, 32'h0, rd);
        check("command", rd, 32'hc);
        $display("test index write done");

        // last pass: 1024 list from 0x7fe must not wrap
        for (int s = 0; s < 4; s++)
        begin
            sz = (s == 3) ? 2'h0 : 2'(s);
            start = (s == 3) ? 14'h07fe : (14'h2000 >> s) - 14'h2;
            wb_wr(8'h20, {28'h0, sz, 2'h0});
            wb_wr(8'h2c, {18'h0, start});
            wb_wr(8'h24, 32'h8);
            wb_wr(8'h20, {28'h0, sz, 2'h1});
            wait_tick(gap);
            wait_tick(gap);
            check("tick gap", 32'(gap), 32'(MF));
            check("sof", {18'h0, sofFrameNumber},
                  {18'h0, start + 14'h2});
            check("entry", {22'h0, frameListEntry},
                  32'(((start + 14'h2) >> 3) & ((14'h400 >> sz) - 1)));
            wb_wr(8'h20, {28'h0, sz, 2'h0});
            wb_cycle(1'b0, 8'h24, 32'h0, rd);
            check("status", rd, (s == 3) ? 32'h0 : 32'h8);
        end
        $display("test counting and wrap done");
        tally_and_finish();
    end

endmodule
